// file: verilog/wiper_map.svh
`ifndef WIPER_MAP_SVH
`define WIPER_MAP_SVH

// fixed upper five bits of the target address byte
`define ADDR_PREFIX 5'h0b
// field positions in the address byte
`define ADDR_STRAP_HIGH_BIT 2
`define ADDR_STRAP_LOW_BIT 1
`define ADDR_DIR_BIT 0
// field positions in the instruction byte
`define INSTR_SEL_BIT 7
`define INSTR_MIDSCALE_BIT 6
`define INSTR_SHUTDOWN_BIT 5
`define INSTR_GP_ONE_BIT 4
`define INSTR_GP_TWO_BIT 3
// wiper codes
`define WIPER_MIDSCALE 8'h80
`define WIPER_RESET 8'h80
// bit counter positions within one nine-clock byte slot
`define LAST_DATA_BIT 4'h7
`define ACK_SLOT 4'h8
// byte index within a frame
`define BYTE_ADDR 2'h0
`define BYTE_INSTR 2'h1
`define BYTE_DATA 2'h2

`endif

// file: verilog/wiper_pkg.sv
package wiper_pkg;

  typedef logic [7:0] wiper_t;

  typedef enum logic [2:0] {
    FR_IDLE   = 3'h1,
    FR_HOLD   = 3'h2,
    FR_ACTIVE = 3'h4
  } frame_state_e;

endpackage

// file: verilog/wiper_link.sv
`timescale 1ns/1ps
`include "wiper_map.svh"

module wiper_link
  import wiper_pkg::*;
(
  // link clock and frame reset
  input wire logic i_scl,
  input wire logic i_link_rst,
  // serial data pin
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // quasi-static values from the system domain
  input wire logic i_addr_strap_high,
  input wire logic i_addr_strap_low,
  input wire wiper_t i_rd_word,
  // write commit towards the system domain
  output logic o_commit_tgl,
  output wiper_t o_instr,
  output wiper_t o_data
);

  logic [3:0] bit_q, bit_d;
  logic [1:0] byte_q, byte_d;
  logic [7:0] shift_q, shift_d;
  logic match_q, match_d;
  logic read_q, read_d;
  logic done_q, done_d;
  logic tgl_q, tgl_d;
  wiper_t instr_q, instr_d;
  wiper_t data_q, data_d;
  logic oe_q, oe_d;
  logic [7:0] full;

  assign full = {shift_q[6:0], i_sda};

  always_comb begin
    bit_d = bit_q;
    byte_d = byte_q;
    shift_d = shift_q;
    match_d = match_q;
    read_d = read_q;
    done_d = done_q;
    tgl_d = tgl_q;
    instr_d = instr_q;
    data_d = data_q;
    if (bit_q == `ACK_SLOT) begin
      bit_d = 4'h0;
      if (byte_q != `BYTE_DATA) begin
        byte_d = byte_q + 2'h1;
      end
      // controller nack ends the read
      if (read_q && byte_q != `BYTE_ADDR && i_sda) begin
        done_d = 1'b1;
      end
      if (match_q && !read_q && byte_q == `BYTE_DATA) begin
        tgl_d = ~tgl_q;
      end
    end else begin
      bit_d = bit_q + 4'h1;
      shift_d = full;
      if (bit_q == `LAST_DATA_BIT) begin
        case (byte_q)
          `BYTE_ADDR: begin
            match_d = (full[7:3] == `ADDR_PREFIX) &&
                      (full[`ADDR_STRAP_HIGH_BIT] == i_addr_strap_high) &&
                      (full[`ADDR_STRAP_LOW_BIT] == i_addr_strap_low);
            read_d = full[`ADDR_DIR_BIT];
          end
          `BYTE_INSTR: begin
            if (match_q && !read_q) begin
              instr_d = full;
            end
          end
          default: begin
            if (match_q && !read_q) begin
              data_d = full;
            end
          end
        endcase
      end
    end
  end

  // frame state restarts on every start condition
  always_ff @(posedge i_scl or posedge i_link_rst) begin
    if (i_link_rst) begin
      bit_q <= 4'h0;
      byte_q <= `BYTE_ADDR;
      shift_q <= 8'h00;
      match_q <= 1'b0;
      read_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
      byte_q <= byte_d;
      shift_q <= shift_d;
      match_q <= match_d;
      read_q <= read_d;
      done_q <= done_d;
    end
  end

  // cleared between frames; the system side ignores changes outside frames
  always_ff @(posedge i_scl or posedge i_link_rst) begin
    if (i_link_rst) begin
      tgl_q <= 1'b0;
    end else begin
      tgl_q <= tgl_d;
    end
  end

  always_ff @(posedge i_scl) begin
    instr_q <= instr_d;
    data_q <= data_d;
  end

  always_comb begin
    oe_d = 1'b0;
    if (match_q) begin
      if (bit_q == `ACK_SLOT) begin
        oe_d = (byte_q == `BYTE_ADDR) || !read_q;
      end else if (read_q && byte_q != `BYTE_ADDR && !done_q) begin
        oe_d = ~i_rd_word[3'h7 - bit_q[2:0]];
      end
    end
  end

  // drive changes while scl is low
  always_ff @(negedge i_scl or posedge i_link_rst) begin
    if (i_link_rst) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= oe_d;
    end
  end

  assign o_sda_o = 1'b0;
  assign o_sda_oe = oe_q;
  assign o_commit_tgl = tgl_q;
  assign o_instr = instr_q;
  assign o_data = data_q;

endmodule

// file: verilog/dual_wiper_serial_control.sv
`timescale 1ns/1ps
`include "wiper_map.svh"

module dual_wiper_serial_control
  import wiper_pkg::*;
#(
  parameter int WIPER_W = 8
)(
  // system clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // serial link pins
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_sda_o,
  output logic o_sda_oe,
  // address straps and shutdown pin
  input wire logic i_addr_strap_high,
  input wire logic i_addr_strap_low,
  input wire logic i_shutdown_pin_n,
  // wiper codes and latched outputs
  output wiper_t o_wiper_one,
  output wiper_t o_wiper_two,
  output logic o_gp_output_one,
  output logic o_gp_output_two,
  // shutdown state and terminal switches
  output logic o_shutdown_active,
  output logic o_wiper_to_b,
  output logic o_terminal_a_open
);

  if (WIPER_W != 8) begin : g_width_check
    $error("wiper width must be 8 to match the data byte");
  end

  // pin synchronisers: scl, sda, strap high, strap low
  logic [3:0] pin_s1_q, pin_s2_q;
  logic scl_h_q, sda_h_q;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pin_s1_q <= 4'hf;
      pin_s2_q <= 4'hf;
      scl_h_q <= 1'b1;
      sda_h_q <= 1'b1;
    end else begin
      pin_s1_q <= {i_scl, i_sda, i_addr_strap_high, i_addr_strap_low};
      pin_s2_q <= pin_s1_q;
      scl_h_q <= pin_s2_q[3];
      sda_h_q <= pin_s2_q[2];
    end
  end

  logic scl_s, sda_s, start_det, stop_det;
  assign scl_s = pin_s2_q[3];
  assign sda_s = pin_s2_q[2];
  assign start_det = scl_s && scl_h_q && sda_h_q && !sda_s;
  assign stop_det = scl_s && scl_h_q && !sda_h_q && sda_s;

  // frame tracker: link logic is held in reset outside frames and until
  // scl first falls after a start, so no scl edge meets a releasing reset
  frame_state_e fr_q, fr_d;
  logic link_rst_q, link_rst_d;

  always_comb begin
    fr_d = fr_q;
    case (fr_q)
      FR_IDLE: begin
        if (start_det) begin
          fr_d = FR_HOLD;
        end
      end
      FR_HOLD: begin
        if (stop_det) begin
          fr_d = FR_IDLE;
        end else if (!scl_s) begin
          fr_d = FR_ACTIVE;
        end
      end
      FR_ACTIVE: begin
        if (stop_det) begin
          fr_d = FR_IDLE;
        end else if (start_det) begin
          fr_d = FR_HOLD;
        end
      end
      default: begin
        fr_d = FR_IDLE;
      end
    endcase
    link_rst_d = (fr_d != FR_ACTIVE);
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fr_q <= FR_IDLE;
      link_rst_q <= 1'b1;
    end else begin
      fr_q <= fr_d;
      link_rst_q <= link_rst_d;
    end
  end

  logic link_rst;
  assign link_rst = link_rst_q || i_rst;

  logic commit_tgl;
  wiper_t instr_w, data_w;
  wiper_t rd_word_q, rd_word_d;

  // read word only changes after a write commit, long before any
  // following read frame can shift it, so it is quasi-static at the link
  wiper_link u_link (
    .i_scl(i_scl),
    .i_link_rst(link_rst),
    .i_sda(i_sda),
    .o_sda_o(o_sda_o),
    .o_sda_oe(o_sda_oe),
    .i_addr_strap_high(pin_s2_q[1]),
    .i_addr_strap_low(pin_s2_q[0]),
    .i_rd_word(rd_word_q),
    .o_commit_tgl(commit_tgl),
    .o_instr(instr_w),
    .o_data(data_w)
  );

  // commit toggle crossing
  logic tgl_s1_q, tgl_s2_q, tgl_h_q;
  logic commit;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tgl_s1_q <= 1'b0;
      tgl_s2_q <= 1'b0;
      tgl_h_q <= 1'b0;
    end else begin
      tgl_s1_q <= commit_tgl;
      tgl_s2_q <= tgl_s1_q;
      tgl_h_q <= tgl_s2_q;
    end
  end

  // toggle returns to 0 at every link reset; only a change inside a frame commits
  assign commit = (tgl_s2_q ^ tgl_h_q) && (fr_q == FR_ACTIVE);

  // wiper_position_register pair and latched instruction fields
  wiper_t wiper_one_q, wiper_one_d;
  wiper_t wiper_two_q, wiper_two_d;
  logic sel_q, sel_d;
  logic shutdown_bit_q, shutdown_bit_d;
  logic gp_one_q, gp_one_d;
  logic gp_two_q, gp_two_d;
  wiper_t load_val;

  always_comb begin
    wiper_one_d = wiper_one_q;
    wiper_two_d = wiper_two_q;
    sel_d = sel_q;
    shutdown_bit_d = shutdown_bit_q;
    gp_one_d = gp_one_q;
    gp_two_d = gp_two_q;
    load_val = instr_w[`INSTR_MIDSCALE_BIT] ? `WIPER_MIDSCALE : data_w;
    if (commit) begin
      sel_d = instr_w[`INSTR_SEL_BIT];
      if (instr_w[`INSTR_SEL_BIT]) begin
        wiper_two_d = load_val;
      end else begin
        wiper_one_d = load_val;
      end
      shutdown_bit_d = instr_w[`INSTR_SHUTDOWN_BIT];
      gp_one_d = instr_w[`INSTR_GP_ONE_BIT];
      gp_two_d = instr_w[`INSTR_GP_TWO_BIT];
    end
    rd_word_d = sel_d ? wiper_two_d : wiper_one_d;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      wiper_one_q <= `WIPER_RESET;
      wiper_two_q <= `WIPER_RESET;
      sel_q <= 1'b0;
      shutdown_bit_q <= 1'b0;
      gp_one_q <= 1'b0;
      gp_two_q <= 1'b0;
      rd_word_q <= `WIPER_RESET;
    end else begin
      wiper_one_q <= wiper_one_d;
      wiper_two_q <= wiper_two_d;
      sel_q <= sel_d;
      shutdown_bit_q <= shutdown_bit_d;
      gp_one_q <= gp_one_d;
      gp_two_q <= gp_two_d;
      rd_word_q <= rd_word_d;
    end
  end

  assign o_wiper_one = wiper_one_q;
  assign o_wiper_two = wiper_two_q;
  assign o_gp_output_one = gp_one_q;
  assign o_gp_output_two = gp_two_q;

  assign o_shutdown_active = shutdown_bit_q || !i_shutdown_pin_n;
  assign o_wiper_to_b = o_shutdown_active;
  assign o_terminal_a_open = o_shutdown_active;

endmodule

// file: bench/dual_wiper_chk.sv
`timescale 1ns/1ps
module dual_wiper_chk
  import wiper_pkg::*;
#(
  parameter int WIPER_W = 8
)(
  // clock, reset, pins
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_scl,
  input wire logic i_shutdown_pin_n,
  // outputs watched
  input wire logic o_sda_o,
  input wire wiper_t o_wiper_one,
  input wire wiper_t o_wiper_two,
  input wire logic o_gp_output_one,
  input wire logic o_gp_output_two,
  input wire logic o_shutdown_active,
  input wire logic o_wiper_to_b,
  input wire logic o_terminal_a_open
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // clocks since scl rose; a commit at stop instead would be late
  // scl high pulses are shorter than a system clock; count them by toggle
  logic scl_t = 1'b0;
  logic scl_q;
  logic [3:0] age_q, age_d;
  always @(posedge i_scl) scl_t <= ~scl_t;
  always_comb begin
    age_d = age_q;
    if (scl_t != scl_q) age_d = 4'h0;
    else if (age_q != 4'hf) age_d = age_q + 4'h1;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_q <= 1'b0;
      age_q <= 4'hf;
    end else begin
      scl_q <= scl_t;
      age_q <= age_d;
    end
  end
  sda_low_a: assert property (o_sda_o == 1'b0)
    else $error("sda value not low");
  pin_sd_a: assert property (!i_shutdown_pin_n |-> o_shutdown_active)
    else $error("pin low, no shutdown");
  to_b_a: assert property (o_wiper_to_b == o_shutdown_active)
    else $error("wiper to b wrong");
  a_open_a: assert property (o_terminal_a_open == o_shutdown_active)
    else $error("terminal a wrong");
  one_wiper_a: assert property (!($changed(o_wiper_one) && $changed(o_wiper_two)))
    else $error("both wipers changed");
  wiper_time_a: assert property (
    ($changed(o_wiper_one) || $changed(o_wiper_two)) |-> age_q <= 4'h4)
    else $error("wiper update mistimed");
  gp_time_a: assert property (
    ($changed(o_gp_output_one) || $changed(o_gp_output_two)) |-> age_q <= 4'h4)
    else $error("gp update mistimed");
  sd_bit_time_a: assert property (($changed(o_shutdown_active) && i_shutdown_pin_n
    && $past(i_shutdown_pin_n)) |-> age_q <= 4'h4)
    else $error("shutdown bit mistimed");
endmodule
bind dual_wiper_serial_control dual_wiper_chk #(.WIPER_W(WIPER_W)) u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl), .i_shutdown_pin_n(i_shutdown_pin_n),
  .o_sda_o(o_sda_o), .o_wiper_one(o_wiper_one), .o_wiper_two(o_wiper_two),
  .o_gp_output_one(o_gp_output_one), .o_gp_output_two(o_gp_output_two),
  .o_shutdown_active(o_shutdown_active), .o_wiper_to_b(o_wiper_to_b),
  .o_terminal_a_open(o_terminal_a_open)
);

// file: bench/i2c_ctrl_model.sv
`timescale 1ns/1ps
module i2c_ctrl_model (
  // bus lines
  output logic o_scl,
  output logic o_sda_drv,
  input wire logic i_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda_drv = 1'b0;
  end
  // data moves while scl low
  // low phase longer than one system clock, so no two samples see scl high
  // across a data change
  task automatic bit_x(input logic b, output logic r);
    #4 o_sda_drv = ~b;
    #22 o_scl = 1'b1;
    r = i_sda;
    #6 o_scl = 1'b0;
  endtask
  task automatic start();
    #4 o_sda_drv = 1'b0;
    #12 o_scl = 1'b1;
    #200 o_sda_drv = 1'b1;
    #200 o_scl = 1'b0;
    // link reset needs to release before the first rising edge
    #200;
  endtask
  task automatic stop();
    #4 o_sda_drv = 1'b1;
    #30 o_scl = 1'b1;
    #200 o_sda_drv = 1'b0;
    #1300;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(b[i], r);
    bit_x(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic nack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      b[i] = r;
    end
    bit_x(nack, r);
  endtask
endmodule

// file: bench/test_dual_wiper_serial_control.sv
`timescale 1ns/1ps
module test_dual_wiper_serial_control;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic pin_n = 1'b1;
  logic [1:0] strap = 2'h2;
  logic scl, drv, sda_o, sda_oe, gp1, gp2, sd, to_b, a_open, ack;
  logic [7:0] w1, w2;
  wire sda;
  int errors = 0;
  int n_checks = 0;
  always #12.5 i_clk = ~i_clk;
  // open drain with pull-up
  assign sda = (drv || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;
  i2c_ctrl_model u_ctl (.o_scl(scl), .o_sda_drv(drv), .i_sda(sda));
  dual_wiper_serial_control #(.WIPER_W(8)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_addr_strap_high(strap[1]), .i_addr_strap_low(strap[0]),
    .i_shutdown_pin_n(pin_n), .o_wiper_one(w1), .o_wiper_two(w2),
    .o_gp_output_one(gp1), .o_gp_output_two(gp2), .o_shutdown_active(sd),
    .o_wiper_to_b(to_b), .o_terminal_a_open(a_open)
  );
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic final_report();
    if (errors == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] ins, input logic [7:0] d);
    u_ctl.start();
    u_ctl.put({5'h0b, a, 1'h0}, ack);
    if (ack) begin
      u_ctl.put(ins, ack);
      u_ctl.put(d, ack);
    end
    #150 u_ctl.stop();
    @(negedge i_clk);
  endtask
  task automatic rd(input logic [7:0] e);
    logic [7:0] b;
    u_ctl.start();
    u_ctl.put({5'h0b, strap, 1'h1}, ack);
    u_ctl.get(1'b1, b);
    chk("rd", e, b);
    u_ctl.stop();
    @(negedge i_clk);
  endtask
  initial begin
    repeat (8) @(negedge i_clk);
    i_rst = 1'b0;
    repeat (4) @(negedge i_clk);
    chk("w1", 8'h80, w1);
    chk("w2", 8'h80, w2);
    wr(2'h2, 8'h18, 8'h3c);
    chk("ack", 8'h01, {7'h0, ack});
    chk("w1", 8'h3c, w1);
    chk("gp", 8'h03, {6'h0, gp1, gp2});
    wr(2'h2, 8'h87, 8'ha5);
    chk("w2", 8'ha5, w2);
    chk("w1", 8'h3c, w1);
    chk("gp", 8'h00, {6'h0, gp1, gp2});
    rd(8'ha5);
    wr(2'h2, 8'h40, 8'h11);
    chk("w1", 8'h80, w1);
    rd(8'h80);
    wr(2'h2, 8'ha0, 8'h22);
    chk("sd", 8'h07, {5'h0, sd, to_b, a_open});
    chk("w2", 8'h22, w2);
    wr(2'h2, 8'h80, 8'h33);
    chk("sd", 8'h00, {5'h0, sd, to_b, a_open});
    pin_n = 1'b0;
    #2 chk("sd", 8'h07, {5'h0, sd, to_b, a_open});
    chk("w2", 8'h33, w2);
    @(negedge i_clk) pin_n = 1'b1;
    wr(2'h1, 8'h00, 8'h55);
    chk("ack", 8'h00, {7'h0, ack});
    chk("w1", 8'h80, w1);
    strap = 2'h1;
    wr(2'h1, 8'h08, 8'h66);
    chk("w1", 8'h66, w1);
    chk("gp", 8'h01, {6'h0, gp1, gp2});
    rd(8'h66);
    final_report();
  end
endmodule
